// file: pkg/rvc_pkg.sv
// constants and types for the regulator three/four voltage control bank
// assumes an apb slave wrapper and otp default inputs from the chip top
//
// Notes on behaviour
// - alt register top bit enables regulator
// - power-save bit selects low-quiescent operation
// - source select picks primary or alternate code
// - writes of codes above ceiling ignored
// - ceiling not 0x00/0x3F makes it read-only
// - regulator four code bit 5 forced one
// - unused bits read zero, read-only
// - all registers return to defaults on reset
// - regulator four uses its own voltage table
`default_nettype none
package rvc_pkg;
	// ----------------------------------------------------------------
	// register map: printed offsets are not word multiples, so indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_R3_PRIMARY = 8'h16;
	localparam logic [7:0] IDX_R3_ALT = 8'h17;
	localparam logic [7:0] IDX_R3_CEIL = 8'h18;
	localparam logic [7:0] IDX_R4_PRIMARY = 8'h19;
	localparam logic [7:0] IDX_R4_ALT = 8'h1a;
	localparam logic [7:0] IDX_R4_CEIL = 8'h1b;
	localparam int ADDR_W = 12;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_ENABLE = 7;
	localparam int BIT_SAVE = 6;
	localparam int BIT_SRC = 6;
	localparam int BIT_FORCED = 5;
	localparam int CODE_W = 6;
	localparam logic [5:0] CEIL_ZERO = 6'h00;
	localparam logic [5:0] CEIL_ONES = 6'h3f;
	// ----------------------------------------------------------------
	// voltage table endpoints in millivolts, regulator four
	// ----------------------------------------------------------------
	localparam int R4_MIN_MV = 1600;
	localparam int R4_MAX_MV = 3300;

	// per regulator state
	typedef struct packed {
		logic src_sel;
		logic [5:0] primary;
		logic enable;
		logic save;
		logic [5:0] alt;
		logic [5:0] ceil;
	} rvc_reg_t;

	// otp defaults for one regulator
	typedef struct packed {
		logic src_sel;
		logic [5:0] primary;
		logic enable;
		logic [5:0] alt;
		logic [5:0] ceil;
	} rvc_otp_t;

	// regulator control outputs
	typedef struct packed {
		logic enable;
		logic save;
		logic [5:0] code;
	} rvc_ctl_t;
endpackage : rvc_pkg
`default_nettype wire

// file: rtl/rvc_chan.sv
// one regulator channel: field storage, rejection of code writes above the ceiling, and lock
// assumes write strobes from the bank decoder on the same clock
`timescale 1ns/10ps
`default_nettype none
module rvc_chan import rvc_pkg::*; #(
	parameter bit FORCE_HI = 1'b0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	// defaults and strap capture
	input wire rvc_otp_t otp,
	input wire logic load_otp,
	// register writes
	input wire logic wr_primary,
	input wire logic wr_alt,
	input wire logic wr_ceil,
	input wire logic [7:0] wdata,
	// state
	output rvc_reg_t regs
);
	logic [5:0] force_mask;
	logic [5:0] wcode;
	logic ceil_locked;

	assign force_mask = FORCE_HI ? 6'h20 : 6'h00;
	assign wcode = wdata[5:0] | force_mask;
	// any ceiling other than all zeros or all ones freezes itself
	assign ceil_locked = (regs.ceil != CEIL_ZERO) &&
		(regs.ceil != CEIL_ONES);

	// field storage; async reset to zero, then otp load on release
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regs <= '0;
		end else if (load_otp) begin
			regs.src_sel <= otp.src_sel;
			regs.primary <= otp.primary | force_mask;
			regs.enable <= otp.enable;
			regs.save <= 1'b0;
			regs.alt <= otp.alt | force_mask;
			regs.ceil <= otp.ceil | force_mask;
		end else if (clk_en) begin
			if (wr_primary) begin
				regs.src_sel <= wdata[BIT_SRC];
				if (wcode <= regs.ceil) begin
					regs.primary <= wcode;
				end
			end
			if (wr_alt) begin
				regs.enable <= wdata[BIT_ENABLE];
				regs.save <= wdata[BIT_SAVE];
				if (wcode <= regs.ceil) begin
					regs.alt <= wcode;
				end
			end
			if (wr_ceil && !ceil_locked) begin
				regs.ceil <= wcode;
			end
		end
	end
endmodule : rvc_chan
`default_nettype wire

// file: rtl/rvc_bank.sv
// apb register bank for regulator three and four voltage control
// assumes otp defaults are stable while rst is high
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module rvc_bank import rvc_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	// otp defaults
	input wire rvc_otp_t otp_r3,
	input wire rvc_otp_t otp_r4,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// regulator controls
	output rvc_ctl_t regulator_three,
	output rvc_ctl_t regulator_four,
	output logic [11:0] reg4_target_mv
);
	// ----------------------------------------------------------------
	// reset release: one cycle of otp load
	// ----------------------------------------------------------------
	logic load_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			load_r <= 1'b1;
		end else begin
			load_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [7:0] idx;
	logic aligned, access, wr, mapped, lane0;
	rvc_reg_t r3, r4;
	assign idx = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
	assign access = psel && penable && !pready && !load_r;
	assign mapped = aligned && (idx >= IDX_R3_PRIMARY) &&
		(idx <= IDX_R4_CEIL);
	assign lane0 = pstrb[0];
	assign wr = access && pwrite && mapped && lane0 && clk_en;

	rvc_chan #(.FORCE_HI(1'b0)) u_r3 (
		.clk_sys(clk_sys),
		.rst(rst),
		.clk_en(clk_en),
		.otp(otp_r3),
		.load_otp(load_r),
		.wr_primary(wr && idx == IDX_R3_PRIMARY),
		.wr_alt(wr && idx == IDX_R3_ALT),
		.wr_ceil(wr && idx == IDX_R3_CEIL),
		.wdata(pwdata[7:0]),
		.regs(r3)
	);
	rvc_chan #(.FORCE_HI(1'b1)) u_r4 (
		.clk_sys(clk_sys),
		.rst(rst),
		.clk_en(clk_en),
		.otp(otp_r4),
		.load_otp(load_r),
		.wr_primary(wr && idx == IDX_R4_PRIMARY),
		.wr_alt(wr && idx == IDX_R4_ALT),
		.wr_ceil(wr && idx == IDX_R4_CEIL),
		.wdata(pwdata[7:0]),
		.regs(r4)
	);

	// read mux; unused bits stay zero
	logic [7:0] rmux;
	always_comb begin
		rmux = 8'h00;
		case (idx)
			IDX_R3_PRIMARY: rmux = {1'b0, r3.src_sel, r3.primary};
			IDX_R3_ALT: rmux = {r3.enable, r3.save, r3.alt};
			IDX_R3_CEIL: rmux = {2'b00, r3.ceil};
			IDX_R4_PRIMARY: rmux = {1'b0, r4.src_sel, r4.primary};
			IDX_R4_ALT: rmux = {r4.enable, r4.save, r4.alt};
			IDX_R4_CEIL: rmux = {2'b00, r4.ceil};
			default: rmux = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// apb answer: one wait state, ready in second access cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			pready <= access;
			pslverr <= access && !mapped;
			prdata <= (access && !pwrite && mapped) ? {24'h00_0000, rmux}
				: 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// regulator control outputs, registered
	// ----------------------------------------------------------------
	logic [11:0] mv_nxt;
	logic [5:0] code4;
	assign code4 = r4.src_sel ? r4.alt : r4.primary;
	// upper half table: 1600 mv at 0x20, 50 mv steps, 3150 mv at 0x3f, below the 3300 clamp
	always_comb begin
		mv_nxt = 12'(R4_MIN_MV + 50 * int'(code4[4:0]));
		if (mv_nxt > 12'(R4_MAX_MV)) begin
			mv_nxt = 12'(R4_MAX_MV);
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regulator_three <= '0;
			regulator_four <= '0;
			reg4_target_mv <= 12'h000;
		end else if (clk_en) begin
			regulator_three.enable <= r3.enable;
			regulator_three.save <= r3.save;
			regulator_three.code <= r3.src_sel ? r3.alt : r3.primary;
			regulator_four.enable <= r4.enable;
			regulator_four.save <= r4.save;
			regulator_four.code <= code4 | 6'h20;
			reg4_target_mv <= mv_nxt;
		end
	end
endmodule : rvc_bank
`default_nettype wire

// file: verif/rvc_bank_monitor.sv
// port checker for the regulator voltage bank
// assumes a bind from the bench top
`timescale 1ns/10ps
`default_nettype none
module rvc_bank_monitor import rvc_pkg::*; (
	// clock, reset, defaults
	input wire logic clk_sys,
	input wire logic rst,
	input wire rvc_otp_t otp_r3,
	// apb
	input wire logic psel,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// controls
	input wire rvc_ctl_t regulator_three,
	input wire rvc_ctl_t regulator_four,
	input wire logic [11:0] reg4_target_mv
);
	// ----
	// properties
	// ----
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// write request seen on the bus
	logic wr_c;
	assign wr_c = psel & pwrite;
	// cycles since reset release, saturating; a plain $past of rst
	// misses a second reset in mid-run, so count instead
	logic [1:0] settle_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			settle_r <= 2'd0;
		end else if (settle_r != 2'd3) begin
			settle_r <= settle_r + 2'd1;
		end
	end
	// defaults land two edges after release
	sequence load_s;
		$fell(rst) ##2 1'b1;
	endsequence
	upper_zero_a: assert property (
		pready && !pwrite |-> prdata[31:8] == '0)
		else $error("read upper bits not zero");
	force_hi_a: assert property (
		settle_r == 2'd3 |-> regulator_four.code[5])
		else $error("regulator four code bit 5 low");
	mv_range_a: assert property (
		settle_r == 2'd3 |-> reg4_target_mv inside {[12'h640:12'hce4]})
		else $error("regulator four target out of range");
	err_resp_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	pulse_one_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	en_cause_a: assert property ($changed(regulator_three.enable) |->
		$past(rst, 3) || $past(wr_c) || $past(wr_c, 2))
		else $error("enable moved without a write");
	save_cause_a: assert property ($changed(regulator_three.save) |->
		$past(rst, 3) || $past(wr_c) || $past(wr_c, 2))
		else $error("power save moved without a write");
	def_load_a: assert property (load_s |->
		regulator_three.enable == otp_r3.enable && !regulator_three.save)
		else $error("defaults not loaded after reset");
endmodule : rvc_bank_monitor
`default_nettype wire

// file: verif/rvc_bank_test.sv
// self-checking bench for the regulator voltage bank
// assumes design, package and monitor compiled first
`timescale 1ns/10ps
`default_nettype none
module rvc_bank_test import rvc_pkg::*; ;
	// ----
	// stimulus and design
	// ----
	logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready;
	logic pslverr, perr;
	logic [11:0] paddr = '0, mv;
	logic [31:0] pwdata = '0, prdata;
	rvc_ctl_t r3, r4;
	int err_total = 0, n_checks = 0;
	// defaults chosen so every field except src_sel differs from zero somewhere
	rvc_otp_t o3 = {1'b0, 6'h39, 1'b1, 6'h10, 6'h3f};
	rvc_otp_t o4 = {1'b0, 6'h04, 1'b0, 6'h02, 6'h3f};
	always #50 clk_sys = ~clk_sys;
	rvc_bank i_rvc_bank (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
		.otp_r3(o3), .otp_r4(o4), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.regulator_three(r3), .regulator_four(r4), .reg4_target_mv(mv));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; only the watchdog ends a dead wait
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk_sys);
		penable <= 1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1);
		// one wait state: ready in the second access cycle
		chk(32'(n), 2);
		q = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk_sys);
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 8'h00, q);
		chk(q, {24'h00_0000, e});
	endtask : rd
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run
	// watchdog at 1000 cycles, far beyond the roughly 150 cycles the tests need
	initial begin
		#100_000;
		err_total++;
		complete_run();
	end
	// main sequence
	initial begin
		logic [7:0] ev [6];
		ev = '{8'h39, 8'h90, 8'h3f, 8'h24, 8'h22, 8'h3f};
		repeat (12) @(posedge clk_sys);
		rst <= 0;
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < 6; i++) begin
			rd(12'h058 + 12'(4 * i), ev[i]);
		end
		$display("defaults done");
		wr(12'h05c, 8'hff);
		rd(12'h05c, 8'hff);
		chk(32'(r3.enable & r3.save), 1);
		wr(12'h058, 8'h45);
		rd(12'h058, 8'h45);
		chk(32'(r3.code), 32'(6'h3f));
		wr(12'h058, 8'h05);
		chk(32'(r3.code), 32'(6'h05));
		$display("fields done");
		wr(12'h060, 8'h10);
		rd(12'h060, 8'h10);
		wr(12'h05c, 8'h20);
		rd(12'h05c, 8'h3f);
		chk(32'(r3.enable), 0);
		wr(12'h060, 8'h3f);
		rd(12'h060, 8'h10);
		wr(12'h058, 8'h11);
		rd(12'h058, 8'h05);
		$display("ceiling done");
		wr(12'h064, 8'h01);
		rd(12'h064, 8'h21);
		chk(32'(mv), 32'(12'h672));
		wr(12'h068, 8'hc3);
		rd(12'h068, 8'he3);
		wr(12'h064, 8'h41);
		chk(32'(r4.code), 32'(6'h23));
		chk(32'(mv), 32'(12'h6d6));
		chk(32'({r4.enable, r4.save}), 32'(2'b11));
		wr(12'h06c, 8'h02);
		rd(12'h06c, 8'h22);
		wr(12'h068, 8'h04);
		rd(12'h068, 8'h23);
		rd(12'h070, 8'h00);
		chk(32'(perr), 1);
		rst <= 1;
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		repeat (3) @(posedge clk_sys);
		rd(12'h060, 8'h3f);
		rd(12'h06c, 8'h3f);
		$display("reg4 and reset done");
		complete_run();
	end
endmodule : rvc_bank_test
bind rvc_bank rvc_bank_monitor i_rvc_bank_monitor (.clk_sys(clk_sys),
	.rst(rst), .otp_r3(otp_r3), .psel(psel), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.regulator_three(regulator_three), .regulator_four(regulator_four),
	.reg4_target_mv(reg4_target_mv));
`default_nettype wire
